// ---- hw/rtc_regs.sv ----
// Timekeeping registers of a real-time clock: BCD seconds to day of month, day of week, calibration.
// Assumes an AXI4-Lite master on aclk and a synchronous active-low reset.
`timescale 1ns/10ps
`include "rtc_map.svh"

// Notes on behaviour
// [R1] Day of month is packed BCD, units 0-9, tens 0-3, legal 1 to 31.
// [R2] Day of month wraps at the month's length, leap years included.
// [R3] Day of week is three bits, steps 1 to 7, then back to 1.
// [R4] Day of week advances with the date but is not derived from it.
// [R5] Hours are packed BCD in 24-hour format, tens 0-2.
// [R6] Minutes are packed BCD, tens 0-5, range 0 to 59.
// [R7] Minutes bit 7 reads zero, bits 6-4 tens, bits 3-0 units.
// [R8] Seconds are packed BCD, tens 0-5, range 0 to 59.
// [R9] Calibration sign 1 adds to the time base, 0 subtracts.
// [R10] Oscillator stop bit 1 halts the time base, 0 lets it run.
// [R11] Seconds carry into minutes, minutes into hours, hours into both day counters.
// [R12] While stopped all counters hold and later resume from held values.
module rtc_regs
    import rtc_pkg::*;
#(
    parameter int ADDR_W     = 8,
    parameter int CNT_W      = 27,
    parameter int SEC_CYCLES = `RTC_SEC_CYCLES
) (
    // Clock and reset.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address and data.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // Write response.
    output rtc_resp_t              s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // Read address and data.
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output rtc_resp_t              s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // Refuse a second count or address width that the prescaler and index decode cannot serve.
    if (SEC_CYCLES < 64 || SEC_CYCLES + 32 >= (64'd1 << CNT_W) || ADDR_W < 6) begin : g_param_check
        $error("rtc_regs: parameters out of range");
    end

    rtc_byte_t            sec, min, hr, dom, cal, mctx;
    logic [2:0]           dow;
    logic [CNT_W-1:0]     presc;
    rtc_byte_t            next_sec, next_min, next_hr, next_dom, next_cal, next_mctx;
    logic [2:0]           next_dow;
    logic [CNT_W-1:0]     next_presc;
    logic                 bvalid, rvalid;
    rtc_resp_t            bresp, rresp;
    logic [31:0]          rdata;
    logic                 next_bvalid, next_rvalid;
    rtc_resp_t            next_bresp, next_rresp;
    logic [31:0]          next_rdata;

    logic                 wr_take, rd_take, wr_hit;
    rtc_byte_t            wr_idx, rd_idx, wbyte;
    logic [CNT_W-1:0]     period_end;
    logic                 tick, sec_wrap, min_wrap, day_adv, osc_stop;
    rtc_byte_t            dom_top;

    function automatic rtc_byte_t bcd_step(input rtc_byte_t v, input rtc_byte_t top, input rtc_byte_t low);
        if (v >= top) begin
            return low;
        end else if (v[3:0] >= 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end else begin
            return {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_step

    // Bus handshakes. Both write channels are taken in the same cycle, so their order does not matter.
    assign wr_take       = s_axi_awvalid && s_axi_wvalid && !bvalid;
    assign rd_take       = s_axi_arvalid && !rvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready  = wr_take;
    assign s_axi_arready = !rvalid;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rresp   = rresp;
    assign s_axi_rdata   = rdata;
    assign wr_idx        = rtc_byte_t'(s_axi_awaddr[ADDR_W-1:2]);
    assign rd_idx        = rtc_byte_t'(s_axi_araddr[ADDR_W-1:2]);
    assign wbyte         = s_axi_wdata[7:0];
    assign wr_hit        = wr_take && s_axi_wstrb[0];

    // Time base and its calibration.
    assign osc_stop = cal[`RTC_CAL_STOP];
    always_comb begin
        if (cal[`RTC_CAL_SIGN]) begin
            period_end = CNT_W'(SEC_CYCLES - 1) - CNT_W'(cal[`RTC_CAL_MAG_W-1:0]); // [R9]
        end else begin
            period_end = CNT_W'(SEC_CYCLES - 1) + CNT_W'(cal[`RTC_CAL_MAG_W-1:0]); // [R9]
        end
    end
    // Compared with >= so that a period shortened mid-count cannot leave the prescaler past its end.
    assign tick = !osc_stop && (presc >= period_end); // [R10]

    always_comb begin
        if (osc_stop) begin
            next_presc = presc; // [R12]
        end else if (tick) begin
            next_presc = '0;
        end else begin
            next_presc = presc + CNT_W'(1);
        end
    end

    // Month length from the month context register, which software keeps.
    always_comb begin
        if (mctx[4:0] == 5'h02) begin
            dom_top = mctx[`RTC_MCTX_LEAP] ? 8'h29 : 8'h28; // [R2]
        end else if (mctx[4:0] == 5'h04 || mctx[4:0] == 5'h06 || mctx[4:0] == 5'h09 || mctx[4:0] == 5'h11) begin
            dom_top = 8'h30; // [R2]
        end else begin
            dom_top = 8'h31; // [R2]
        end
    end

    // Cascade of the counters.
    assign sec_wrap = tick && (sec >= `RTC_TOP_SEC); // [R11]
    assign min_wrap = sec_wrap && (min >= `RTC_TOP_MIN); // [R11]
    assign day_adv  = min_wrap && (hr >= `RTC_TOP_HR); // [R11]

    // A write in the same cycle as a carry wins; the carry into that one register is dropped.
    always_comb begin
        next_sec  = sec;
        next_min  = min;
        next_hr   = hr;
        next_dom  = dom;
        next_dow  = dow;
        next_cal  = cal;
        next_mctx = mctx;
        if (tick) begin
            next_sec = bcd_step(sec, `RTC_TOP_SEC, 8'h00); // [R8]
        end
        if (sec_wrap) begin
            next_min = bcd_step(min, `RTC_TOP_MIN, 8'h00); // [R6]
        end
        if (min_wrap) begin
            next_hr = bcd_step(hr, `RTC_TOP_HR, 8'h00); // [R5]
        end
        if (day_adv) begin
            next_dom = bcd_step(dom, dom_top, `RTC_FIRST_DAY); // [R1] [R2]
            next_dow = (dow >= 3'(`RTC_TOP_DOW) || dow == 3'h0) ? 3'h1 : dow + 3'h1; // [R3] [R4]
        end
        // Masks keep only the bits each counter owns, so the unused bits always read zero.
        if (wr_hit) begin
            if (wr_idx == `RTC_IDX_SEC) begin
                next_sec = wbyte & `RTC_MASK_SEC; // [R8]
            end else if (wr_idx == `RTC_IDX_MIN) begin
                next_min = wbyte & `RTC_MASK_MIN; // [R7]
            end else if (wr_idx == `RTC_IDX_HR) begin
                next_hr = wbyte & `RTC_MASK_HR; // [R5]
            end else if (wr_idx == `RTC_IDX_DOW) begin
                next_dow = wbyte[2:0];
            end else if (wr_idx == `RTC_IDX_DOM) begin
                next_dom = wbyte & `RTC_MASK_DOM; // [R1]
            end else if (wr_idx == `RTC_IDX_CAL) begin
                next_cal = wbyte & `RTC_MASK_CAL;
            end else if (wr_idx == `RTC_IDX_MCTX) begin
                next_mctx = wbyte & `RTC_MASK_MCTX;
            end
        end
    end

    // Bus responses.
    always_comb begin
        next_bvalid = bvalid;
        next_bresp  = bresp;
        next_rvalid = rvalid;
        next_rresp  = rresp;
        next_rdata  = rdata;
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wr_take) begin
            next_bvalid = 1'b1;
            if (wr_idx >= `RTC_IDX_CAL && wr_idx <= `RTC_IDX_MCTX) begin
                next_bresp = `RTC_RESP_OKAY;
            end else begin
                next_bresp = `RTC_RESP_SLVERR;
            end
        end
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (rd_take) begin
            next_rvalid = 1'b1;
            next_rresp  = `RTC_RESP_OKAY;
            next_rdata  = '0;
            if (rd_idx == `RTC_IDX_SEC) begin
                next_rdata[7:0] = sec;
            end else if (rd_idx == `RTC_IDX_MIN) begin
                next_rdata[7:0] = min; // [R7]
            end else if (rd_idx == `RTC_IDX_HR) begin
                next_rdata[7:0] = hr;
            end else if (rd_idx == `RTC_IDX_DOW) begin
                next_rdata[2:0] = dow;
            end else if (rd_idx == `RTC_IDX_DOM) begin
                next_rdata[7:0] = dom;
            end else if (rd_idx == `RTC_IDX_CAL) begin
                next_rdata[7:0] = cal;
            end else if (rd_idx == `RTC_IDX_MCTX) begin
                next_rdata[7:0] = mctx;
            end else begin
                next_rresp = `RTC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec    <= `RTC_RST_SEC;
            min    <= `RTC_RST_MIN;
            hr     <= `RTC_RST_HR;
            dom    <= `RTC_RST_DOM;
            dow    <= 3'(`RTC_RST_DOW);
            cal    <= `RTC_RST_CAL;
            mctx   <= `RTC_RST_MCTX;
            presc  <= '0;
            bvalid <= 1'b0;
            bresp  <= `RTC_RESP_OKAY;
            rvalid <= 1'b0;
            rresp  <= `RTC_RESP_OKAY;
            rdata  <= '0;
        end else begin
            sec    <= next_sec;
            min    <= next_min;
            hr     <= next_hr;
            dom    <= next_dom;
            dow    <= next_dow;
            cal    <= next_cal;
            mctx   <= next_mctx;
            presc  <= next_presc;
            bvalid <= next_bvalid;
            bresp  <= next_bresp;
            rvalid <= next_rvalid;
            rresp  <= next_rresp;
            rdata  <= next_rdata;
        end
    end

    // Checks on the counters and on the read channel.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence sec_last_s;
        tick && sec == 8'h59 && !wr_hit;
    endsequence
    sequence min_moved_s;
        min != $past(min) || min == 8'h00;
    endsequence

    dom_layout_a: assert property (dom[7:6] == 2'h0) // [R1]
        else $error("day of month upper bits set");
    dom_feb_a: assert property (day_adv && !wr_hit && mctx == 8'h02 && dom == 8'h28 |=> dom == 8'h01) // [R2]
        else $error("february did not wrap after 28");
    dom_leap_a: assert property (day_adv && !wr_hit && mctx == 8'h82 && dom == 8'h28 |=> dom == 8'h29) // [R2]
        else $error("leap february wrapped early");
    dow_wrap_a: assert property (day_adv && !wr_hit && dow == 3'h7 |=> dow == 3'h1) // [R3]
        else $error("day of week did not return to 1");
    dow_with_date_a: assert property (day_adv && !wr_hit && dow == 3'h3 |=> dow == 3'h4 && dom != $past(dom)) // [R4]
        else $error("day of week and date did not step together");
    hr_wrap_a: assert property (min_wrap && !wr_hit && hr == 8'h23 |=> hr == 8'h00) // [R5]
        else $error("hours did not wrap at 23");
    min_bit7_a: assert property (min[7] == 1'b0) // [R7]
        else $error("minutes bit 7 set");
    min_carry_a: assert property (sec_last_s |=> sec == 8'h00 ##0 min_moved_s) // [R6] [R8] [R11]
        else $error("seconds wrap did not carry into minutes");
    cal_add_a: assert property (tick && cal[`RTC_CAL_SIGN] |-> presc == CNT_W'(SEC_CYCLES - 1) - CNT_W'(cal[4:0])) // [R9]
        else $error("positive calibration period wrong");
    cal_sub_a: assert property (tick && !cal[`RTC_CAL_SIGN] |-> presc == CNT_W'(SEC_CYCLES - 1) + CNT_W'(cal[4:0])) // [R9]
        else $error("negative calibration period wrong");
    osc_stop_a: assert property (osc_stop |-> !tick) // [R10]
        else $error("time base ran while stopped");
    osc_hold_a: assert property (osc_stop && !wr_hit |=> $stable(sec) && $stable(min) && $stable(presc)) // [R12]
        else $error("counters moved while stopped");
    hr_carry_a: assert property (min_wrap && !wr_hit |=> hr != $past(hr)) // [R11]
        else $error("minutes wrap did not carry into hours");
    dom_short_a: assert property (day_adv && !wr_hit && mctx == 8'h04 && dom == 8'h30 |=> dom == 8'h01) // [R2]
        else $error("thirty day month did not wrap after 30");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> rvalid)
        else $error("read request was not answered");

endmodule : rtc_regs

// ---- common/rtc_map.svh ----
// Register indices, field positions, reset values and timing figures of the clock registers.
// Assumes inclusion by bare name from the package and the design file.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define RTC_IDX_CAL      8'h08
`define RTC_IDX_SEC      8'h09
`define RTC_IDX_MIN      8'h0a
`define RTC_IDX_HR       8'h0b
`define RTC_IDX_DOW      8'h0c
`define RTC_IDX_DOM      8'h0d
`define RTC_IDX_MCTX     8'h0e
`define RTC_MASK_SEC     8'h7f
`define RTC_MASK_MIN     8'h7f
`define RTC_MASK_HR      8'h3f
`define RTC_MASK_DOW     8'h07
`define RTC_MASK_DOM     8'h3f
`define RTC_MASK_CAL     8'hbf
`define RTC_MASK_MCTX    8'h9f
`define RTC_CAL_STOP     7
`define RTC_CAL_SIGN     5
`define RTC_CAL_MAG_W    5
`define RTC_MCTX_LEAP    7
`define RTC_RST_SEC      8'h00
`define RTC_RST_MIN      8'h00
`define RTC_RST_HR       8'h00
`define RTC_RST_DOW      8'h01
`define RTC_RST_DOM      8'h01
`define RTC_RST_CAL      8'h00
`define RTC_RST_MCTX     8'h01
`define RTC_TOP_SEC      8'h59
`define RTC_TOP_MIN      8'h59
`define RTC_TOP_HR       8'h23
`define RTC_TOP_DOW      8'h07
`define RTC_FIRST_DAY    8'h01
`define RTC_SEC_NS       1000000000
`define RTC_CLK_NS       10
`define RTC_SEC_CYCLES   (`RTC_SEC_NS / `RTC_CLK_NS)
`define RTC_RESP_OKAY    2'h0
`define RTC_RESP_SLVERR  2'h2
`endif

// ---- common/rtc_pkg.sv ----
// Types shared by the clock register block.
// Assumes rtc_map.svh is on the include path.
`include "rtc_map.svh"
package rtc_pkg;
    typedef logic [7:0] rtc_byte_t;
    typedef logic [1:0] rtc_resp_t;
endpackage : rtc_pkg

// ---- verification/rtc_bcd_timekeeping_regs_tb.sv ----
// Self-checking bench for the clock register block, driven over AXI4-Lite.
// Assumes rtc_map.svh and rtc_pkg are compiled first; one 100 MHz clock, short second count.
`timescale 1ns/10ps
`include "rtc_map.svh"
module rtc_bcd_timekeeping_regs_tb
    import rtc_pkg::*;
;
    localparam int SEC_CYC = 100;
    // Clock, reset and bus signals.
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    rtc_resp_t   s_axi_bresp, s_axi_rresp;
    int          err_count, n_checks, cyc, m_s, m_mi, m_h, m_dw, m_dm, m_mo, m_lp, t0, per;
    logic [31:0] seed, d;
    rtc_resp_t   r;
    int t_mo[5] = '{2, 2, 4, 12, 1};
    int t_lp[5] = '{0, 1, 0, 0, 0};
    int t_dm[5] = '{28, 28, 30, 31, 15};
    int t_dw[5] = '{7, 3, 5, 6, 2};
    logic [7:0] t_cal[3] = '{8'h2a, 8'h0a, 8'h00};
    int t_per[3] = '{SEC_CYC - 10, SEC_CYC + 10, SEC_CYC};

    rtc_regs #(.SEC_CYCLES(SEC_CYC)) rtc_regs_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] bcd(input int v);
        return 32'((v / 10) * 16 + v % 10);
    endfunction : bcd
    function automatic int mlen();
        if (m_mo == 2) return m_lp ? 29 : 28;
        if (m_mo == 4 || m_mo == 6 || m_mo == 9 || m_mo == 11) return 30;
        return 31;
    endfunction : mlen
    task automatic model_step();
        m_s++;
        if (m_s == 60) begin
            m_s = 0;
            m_mi++;
        end
        if (m_mi == 60) begin
            m_mi = 0;
            m_h++;
        end
        if (m_h == 24) begin
            m_h = 0;
            m_dw = (m_dw == 7) ? 1 : m_dw + 1;
            m_dm = (m_dm == mlen()) ? 1 : m_dm + 1;
        end
    endtask : model_step

    // Ready is sampled on the falling edge, where it already shows what the next rising edge sees.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output rtc_resp_t rs);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin @(negedge aclk); n++; end while ((s_axi_awready && s_axi_wready) !== 1'b1 && n < 200);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do begin @(negedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 200);
        rs = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
        chk(32'(n < 200), 32'h1);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output rtc_resp_t rs);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin @(negedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 200);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 200);
        v  = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
        chk(32'(n < 200), 32'h1);
    endtask : axi_read
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        axi_write({idx[5:0], 2'b00}, v, r);
        chk({30'h0, r}, {30'h0, `RTC_RESP_OKAY});
    endtask : wr
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        axi_read({idx[5:0], 2'b00}, d, r);
        chk({30'h0, r}, {30'h0, `RTC_RESP_OKAY});
        chk(d, exp);
    endtask : rchk
    task automatic chk_all();
        rchk(`RTC_IDX_SEC, bcd(m_s));
        rchk(`RTC_IDX_MIN, bcd(m_mi));
        rchk(`RTC_IDX_HR, bcd(m_h));
        rchk(`RTC_IDX_DOW, 32'(m_dw));
        rchk(`RTC_IDX_DOM, bcd(m_dm));
    endtask : chk_all
    // Polling costs a few cycles per read, so a tick is seen a little late; periods allow for it.
    task automatic wait_tick();
        logic [31:0] d0;
        int n;
        axi_read({`RTC_IDX_SEC, 2'b00}, d0, r);
        n = 0;
        do begin axi_read({`RTC_IDX_SEC, 2'b00}, d, r); n++; end while (d === d0 && n < 100);
        chk(32'(d !== d0), 32'h1);
    endtask : wait_tick
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {err_count, n_checks} = '0;
        seed = 32'd55922;
        {m_s, m_mi, m_h, m_dw, m_dm, m_mo, m_lp} = {32'd0, 32'd0, 32'd0, 32'd1, 32'd1, 32'd1, 32'd0};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wr(`RTC_IDX_CAL, 32'h80);
        chk_all();
        axi_read(8'h00, d, r);
        chk({30'h0, r}, {30'h0, `RTC_RESP_SLVERR});
        chk(d, 32'h0);
        axi_write(8'h3c, xs(), r);
        chk({30'h0, r}, {30'h0, `RTC_RESP_SLVERR});
        // Random words land only in the bits each counter owns.
        for (int i = 9; i <= 13; i++) begin
            t0 = int'(xs());
            wr(8'(i), 32'(t0));
            case (i)
                9: rchk(8'(i), 32'(t0) & 32'(`RTC_MASK_SEC));
                10: rchk(8'(i), 32'(t0) & 32'(`RTC_MASK_MIN));
                11: rchk(8'(i), 32'(t0) & 32'(`RTC_MASK_HR));
                12: rchk(8'(i), 32'(t0) & 32'(`RTC_MASK_DOW));
                default: rchk(8'(i), 32'(t0) & 32'(`RTC_MASK_DOM));
            endcase
        end
        // Last second of a day rolls into the next date for several month lengths.
        for (int k = 0; k < 5; k++) begin
            {m_s, m_mi, m_h, m_dw, m_dm, m_mo, m_lp} = {32'd59, 32'd59, 32'd23, t_dw[k], t_dm[k], t_mo[k], t_lp[k]};
            wr(`RTC_IDX_SEC, bcd(m_s));
            wr(`RTC_IDX_MIN, bcd(m_mi));
            wr(`RTC_IDX_HR, bcd(m_h));
            wr(`RTC_IDX_DOW, 32'(m_dw));
            wr(`RTC_IDX_DOM, bcd(m_dm));
            wr(`RTC_IDX_MCTX, bcd(m_mo) | 32'(m_lp << 7));
            repeat (2 * SEC_CYC) @(posedge aclk);
            rchk(`RTC_IDX_SEC, bcd(m_s));
            wr(`RTC_IDX_CAL, 32'h00);
            wait_tick();
            wr(`RTC_IDX_CAL, 32'h80);
            model_step();
            chk_all();
        end
        for (int k = 0; k < 3; k++) begin
            wr(`RTC_IDX_CAL, 32'(t_cal[k]));
            rchk(`RTC_IDX_CAL, 32'(t_cal[k]));
            wait_tick();
            t0 = cyc;
            repeat (3) wait_tick();
            per = (cyc - t0) / 3;
            chk(32'((per > t_per[k] - 5 && per < t_per[k] + 5) ? t_per[k] : per), 32'(t_per[k]));
        end
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge aclk);
        err_count++;
        give_verdict();
    end
endmodule : rtc_bcd_timekeeping_regs_tb
